// File: gpx_master.sv
// two-wire bus master model driving the clock and data lines
`timescale 1ns/1ps
module gpx_master (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask : wt
   // low phase of 14 cycles keeps the minimum clock low time
   task automatic put_bit(input logic b, output logic r);
      o_scl <= 1'b0;
      wt(7);
      o_sda_low <= ~b;
      wt(7);
      o_scl <= 1'b1;
      wt(5);
      r = i_sda;
      wt(5);
   endtask : put_bit
   task automatic bus_start();
      o_scl <= 1'b0;
      wt(7);
      o_sda_low <= 1'b0;
      wt(7);
      o_scl <= 1'b1;
      wt(10);
      o_sda_low <= 1'b1;
      wt(10);
   endtask : bus_start
   task automatic bus_stop();
      o_scl <= 1'b0;
      wt(7);
      o_sda_low <= 1'b1;
      wt(7);
      o_scl <= 1'b1;
      wt(10);
      o_sda_low <= 1'b0;
      wt(20);
   endtask : bus_stop
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(d[i], r);
      put_bit(1'b1, r);
      ack = ~r;
   endtask : put_byte
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         d[i] = r;
      end
      put_bit(nack, r);
   endtask : get_byte
endmodule : gpx_master

// File: gpx_pkg.sv
// constants for the two-wire gpio port expander
//
// Contract
// - ignore bus until start: sda falls while scl high
// - stop (sda rises while scl high) ends current operation
// - sda change while scl high is start or stop, never data
// - address byte: top nibble 0100, next three bits match select pins
// - eighth address bit: 1 starts read, 0 starts write
// - acknowledge address only on match, then read or write
// - receiver pulls sda low through the ninth clock high phase
// - in write, acknowledge every byte after the address
// - read shifts eight bits, samples master ack, continues on ack
// - on master nack stop sending and wait for stop
// - first write byte after address is the register pointer
// - pointer 0 input, 1 output level, 2 polarity, 3 direction
// - input register shows every pin level, input or output
// - writes to the input register are discarded
// - input pin has both drivers off; output pin drives push-pull
// - alert active when an input pin differs from its stored bit
// - alert released on return to earlier level or input read
// - output-to-input switch may raise a spurious alert
// - direction bit set makes input; all inputs after reset
// - polarity bit set inverts reported input bit
// - output register reads flip-flop values, drive only outputs
// - pointer persists for reads until a new command byte
package gpx_pkg;
   localparam logic [3:0] ADDR_FIXED = 4'h4;
   localparam logic [1:0] REG_IN = 2'h0;
   localparam logic [1:0] REG_OUT = 2'h1;
   localparam logic [1:0] REG_POL = 2'h2;
   localparam logic [1:0] REG_DIR = 2'h3;
   localparam logic [7:0] RST_OUT = 8'hFF;
   localparam logic [7:0] RST_POL = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_IN = 8'hFF;
   // noise pulse filtered on the bus lines
   localparam int FILT_NS = 100;
   localparam int CLK_NS = 100;
   localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] FILT_CNT = 2'(FILT_CYC);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_WACK = 3'b010,
      ST_WRX = 3'b011,
      ST_RTX = 3'b100,
      ST_RACK = 3'b101,
      ST_WAITP = 3'b110
   } gpx_state_e;
endpackage : gpx_pkg

// File: gpx_top.sv
// two-wire slave with four byte registers, eight port pins and alert
`timescale 1ns/1ps
module gpx_top
   import gpx_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_port_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_addr_select_bit0,
   input wire logic i_addr_select_bit1,
   input wire logic i_addr_select_bit2,
   input wire logic [7:0] i_port_pins,
   output logic [7:0] o_port_pins,
   output logic [7:0] o_pin_high_driver,
   output logic [7:0] o_pin_low_driver,
   output logic [7:0] o_port_pins_oe,
   output logic o_alert,
   output logic o_alert_oe
);
   // bus synchronisers and filter, all on i_mclk
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_f;
   logic sda_f;
   logic scl_d;
   logic sda_d;
   logic [1:0] scl_cnt;
   logic [1:0] sda_cnt;
   // port pins come from the port-side clock domain
   logic [7:0] pin_m1;
   logic [7:0] pin_m2;
   logic [7:0] pin_level_out;
   logic [7:0] pin_polarity_invert;
   logic [7:0] pin_direction;
   logic [7:0] pin_level_in;
   logic [1:0] ptr;
   logic ptr_new;
   gpx_state_e state;
   logic [7:0] shreg;
   logic [3:0] bitcnt;
   logic rw;
   logic sda_drv;
   logic alert_m;
   // port clock side
   logic [7:0] out_p1;
   logic [7:0] out_p2;
   logic [7:0] dir_p1;
   logic [7:0] dir_p2;
   logic [7:0] pin_p1;
   logic [7:0] pin_p2;

   // glitches shorter than the filter never reach the edge logic
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
      end else begin
         scl_sync <= {scl_sync[0], i_scl};
         sda_sync <= {sda_sync[0], i_sda};
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_cnt <= 2'h0;
         sda_cnt <= 2'h0;
      end else begin
         if (scl_sync[1] == scl_f) scl_cnt <= 2'h0;
         else if (scl_cnt == FILT_CNT) begin
            scl_f <= scl_sync[1];
            scl_cnt <= 2'h0;
         end else scl_cnt <= scl_cnt + 2'h1;
         if (sda_sync[1] == sda_f) sda_cnt <= 2'h0;
         else if (sda_cnt == FILT_CNT) begin
            sda_f <= sda_sync[1];
            sda_cnt <= 2'h0;
         end else sda_cnt <= sda_cnt + 2'h1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   wire scl_rise = scl_f & ~scl_d;
   wire scl_fall = ~scl_f & scl_d;
   wire start_c = scl_f & scl_d & sda_d & ~sda_f;
   wire stop_c = scl_f & scl_d & ~sda_d & sda_f;
   wire [2:0] sel_pins = {i_addr_select_bit2, i_addr_select_bit1, i_addr_select_bit0};
   wire [7:0] rx_byte = {shreg[6:0], sda_f};
   wire addr_hit = (rx_byte[7:4] == ADDR_FIXED) && (rx_byte[3:1] == sel_pins);
   wire byte_done = scl_rise && (bitcnt == 4'd7);
   wire [7:0] in_view = pin_m2 ^ pin_polarity_invert;
   wire [7:0] rd_data = (ptr == REG_IN) ? in_view :
                        (ptr == REG_OUT) ? pin_level_out :
                        (ptr == REG_POL) ? pin_polarity_invert : pin_direction;
   wire wr_strobe = (state == ST_WRX) && byte_done && !ptr_new;
   wire in_read = (state == ST_RTX) && (ptr == REG_IN) && scl_rise && (bitcnt == 4'd0);
   wire [7:0] alert_diff = (pin_m2 ^ pin_level_in) & pin_direction;

   // byte-level protocol engine
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= ST_IDLE;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         rw <= 1'b0;
         sda_drv <= 1'b0;
         ptr <= REG_IN;
         ptr_new <= 1'b0;
      end else if (start_c) begin
         state <= ST_ADDR;
         bitcnt <= 4'h0;
         sda_drv <= 1'b0;
      end else if (stop_c) begin
         state <= ST_IDLE;
         sda_drv <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: sda_drv <= 1'b0;
            ST_ADDR: begin
               if (scl_rise) begin
                  shreg <= rx_byte;
                  bitcnt <= bitcnt + 4'h1;
               end
               if (byte_done) begin
                  rw <= sda_f;
                  state <= addr_hit ? ST_WACK : ST_WAITP;
               end
            end
            ST_WACK: begin
               if (scl_fall && !sda_drv) sda_drv <= 1'b1;
               else if (scl_fall && sda_drv) begin
                  sda_drv <= 1'b0;
                  bitcnt <= 4'h0;
                  if (rw) begin
                     state <= ST_RTX;
                     shreg <= rd_data;
                     sda_drv <= ~rd_data[7];
                  end else state <= ST_WRX;
               end
            end
            ST_WRX: begin
               if (scl_rise) begin
                  shreg <= rx_byte;
                  bitcnt <= bitcnt + 4'h1;
               end
               if (byte_done) begin
                  state <= ST_WACK;
                  if (ptr_new) begin
                     ptr <= rx_byte[1:0];
                     ptr_new <= 1'b0;
                  end
               end
            end
            ST_RTX: begin
               if (scl_fall) begin
                  if (bitcnt == 4'd8) begin
                     sda_drv <= 1'b0;
                     state <= ST_RACK;
                  end else if (bitcnt == 4'hF) begin
                     // later bytes: msb goes out at the fall after the ack clock
                     sda_drv <= ~shreg[7];
                     bitcnt <= 4'h0;
                  end else begin
                     shreg <= {shreg[6:0], 1'b0};
                     sda_drv <= ~shreg[6];
                  end
               end
               if (scl_rise) bitcnt <= bitcnt + 4'h1;
            end
            ST_RACK: begin
               if (scl_rise) state <= sda_f ? ST_WAITP : ST_RTX;
               if (scl_rise) begin
                  bitcnt <= 4'hF;
                  shreg <= rd_data;
               end
            end
            ST_WAITP: sda_drv <= 1'b0;
            default: state <= ST_IDLE;
         endcase
         // fresh write transaction expects a pointer byte first
         if (state == ST_ADDR && byte_done && addr_hit && !sda_f) ptr_new <= 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sda <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         o_sda <= 1'b0;
         o_sda_oe <= sda_drv;
      end
   end

   // register writes; input register ignores them
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_level_out <= RST_OUT;
         pin_polarity_invert <= RST_POL;
         pin_direction <= RST_DIR;
      end else if (wr_strobe) begin
         case (ptr)
            REG_OUT: pin_level_out <= rx_byte;
            REG_POL: pin_polarity_invert <= rx_byte;
            REG_DIR: pin_direction <= rx_byte;
            default: ;
         endcase
      end
   end

   // snapshot of pins refreshed by an input register read
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) pin_level_in <= RST_IN;
      else if (in_read) pin_level_in <= pin_m2;
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_m1 <= 8'hFF;
         pin_m2 <= 8'hFF;
         alert_m <= 1'b0;
      end else begin
         pin_m1 <= pin_p2;
         pin_m2 <= pin_m1;
         alert_m <= |alert_diff;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_alert <= 1'b0;
         o_alert_oe <= 1'b0;
      end else begin
         o_alert <= 1'b0;
         o_alert_oe <= alert_m;
      end
   end

   // port clock domain: pins sampled, drivers steered from synced config
   always_ff @(posedge i_port_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_p1 <= 8'hFF;
         pin_p2 <= 8'hFF;
         out_p1 <= RST_OUT;
         out_p2 <= RST_OUT;
         dir_p1 <= RST_DIR;
         dir_p2 <= RST_DIR;
      end else begin
         pin_p1 <= i_port_pins;
         pin_p2 <= pin_p1;
         out_p1 <= pin_level_out;
         out_p2 <= out_p1;
         dir_p1 <= pin_direction;
         dir_p2 <= dir_p1;
      end
   end

   always_ff @(posedge i_port_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_port_pins <= RST_OUT;
         o_port_pins_oe <= 8'h00;
         o_pin_high_driver <= 8'h00;
         o_pin_low_driver <= 8'h00;
      end else begin
         o_port_pins <= out_p2;
         o_port_pins_oe <= ~dir_p2;
         o_pin_high_driver <= ~dir_p2 & out_p2;
         o_pin_low_driver <= ~dir_p2 & ~out_p2;
      end
   end

   // both stage enables at once would short the pin supply
   AST_DRV_EXCL: assert property (@(posedge i_port_clk) disable iff (!i_rstn)
      (o_pin_high_driver & o_pin_low_driver) == 8'h00)
      else $error("both pin drivers on");
   AST_IN_HIZ: assert property (@(posedge i_port_clk) disable iff (!i_rstn)
      ((o_pin_high_driver | o_pin_low_driver) & ~o_port_pins_oe) == 8'h00)
      else $error("input pin driven");

   AST_NO_ACK_MISMATCH: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (state == ST_ADDR && byte_done && !addr_hit) |=> !sda_drv)
      else $error("ack on address mismatch");
   AST_START_ADDR: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      start_c |=> state == ST_ADDR)
      else $error("start not taken");
   AST_STOP_IDLE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (stop_c && !start_c) |=> state == ST_IDLE)
      else $error("stop not taken");
   AST_IN_RO: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (wr_strobe && ptr == REG_IN) |=> $stable(pin_level_out) && $stable(pin_direction))
      else $error("input register write changed state");
   AST_DIR_RESET: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      $rose(i_rstn) |-> pin_direction == RST_DIR)
      else $error("direction not inputs");
   AST_ALERT: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (|alert_diff) |=> ##1 o_alert_oe)
      else $error("alert not raised");
   AST_NACK_WAIT: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (state == ST_RACK && scl_rise && sda_f && !stop_c && !start_c) |=> state == ST_WAITP)
      else $error("nack not honoured");
   AST_ADDR_ACK: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (state == ST_ADDR && byte_done && addr_hit && !start_c && !stop_c) |=> state == ST_WACK)
      else $error("address match not acked");
endmodule : gpx_top

// File: gpx_top_tb_top.sv
// self-checking bench for the two-wire port expander
`timescale 1ns/1ps
module gpx_top_tb_top;
   logic clk = 1'b0;
   logic pclk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] strap = 3'b101;
   logic [7:0] ext = 8'hFF;
   logic scl, m_low, sda_oe, sda_o, alert, alert_oe;
   logic [7:0] pins_o, pins_oe, hi_drv, lo_drv;
   wire sda;
   wire [7:0] pins;
   int errors = 0;
   int check_count = 0;
   always #50 clk = ~clk;
   initial begin
      #17;
      forever #40 pclk = ~pclk;
   end
   // pull-up on the data line; output pins show what the device drives
   assign sda = (m_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
   assign pins = (pins_oe & pins_o) | (~pins_oe & ext);
   gpx_top i_dut (.i_mclk(clk), .i_rstn(rstn), .i_port_clk(pclk), .i_scl(scl), .i_sda(sda),
      .o_sda(sda_o), .o_sda_oe(sda_oe), .i_addr_select_bit0(strap[0]),
      .i_addr_select_bit1(strap[1]), .i_addr_select_bit2(strap[2]), .i_port_pins(pins),
      .o_port_pins(pins_o), .o_pin_high_driver(hi_drv), .o_pin_low_driver(lo_drv),
      .o_port_pins_oe(pins_oe), .o_alert(alert), .o_alert_oe(alert_oe));
   gpx_master i_master (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize
   task automatic wc(input int n);
      repeat (n) @(posedge clk);
   endtask : wc
   task automatic setp(input logic [7:0] v);
      @(posedge clk);
      ext <= v;
      wc(40);
   endtask : setp
   task automatic put(input logic [7:0] b, input logic exp);
      logic a;
      i_master.put_byte(b, a);
      chk({7'h0, a}, {7'h0, exp});
   endtask : put
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      i_master.bus_start();
      put({4'h4, strap, 1'b0}, 1'b1);
      put(p, 1'b1);
      put(d, 1'b1);
      i_master.bus_stop();
      wc(10);
   endtask : wr
   task automatic rd_again(input logic [7:0] exp);
      logic [7:0] d;
      i_master.bus_start();
      put({4'h4, strap, 1'b1}, 1'b1);
      i_master.get_byte(1'b1, d);
      chk(d, exp);
      i_master.bus_stop();
   endtask : rd_again
   task automatic rd_ptr(input logic [7:0] p, input logic [7:0] exp);
      i_master.bus_start();
      put({4'h4, strap, 1'b0}, 1'b1);
      put(p, 1'b1);
      rd_again(exp);
   endtask : rd_ptr
   task automatic t_reset();
      chk(pins_oe, 8'h00);
      chk(hi_drv | lo_drv, 8'h00);
      chk({7'h0, alert_oe}, 8'h00);
      chk({6'h0, sda_o, alert}, 8'h00);
      rd_ptr(8'h01, 8'hFF);
      rd_ptr(8'h02, 8'h00);
      rd_ptr(8'h03, 8'hFF);
      rd_again(8'hFF);
      rd_ptr(8'h00, 8'hFF);
   endtask : t_reset
   task automatic t_output();
      wr(8'h01, 8'h3C);
      wr(8'h03, 8'h0F);
      chk(pins_oe, 8'hF0);
      chk(hi_drv, 8'h30);
      chk(lo_drv, 8'hC0);
      chk(pins_o & 8'hF0, 8'h30);
      setp(8'h5A);
      rd_ptr(8'h00, 8'h3A);
      rd_ptr(8'h01, 8'h3C);
   endtask : t_output
   task automatic t_polarity();
      wr(8'h02, 8'h0F);
      rd_ptr(8'h00, 8'h35);
      wr(8'h00, 8'h00);
      rd_ptr(8'h02, 8'h0F);
      rd_ptr(8'h03, 8'h0F);
      rd_ptr(8'h01, 8'h3C);
      wr(8'h02, 8'h00);
   endtask : t_polarity
   task automatic t_alert();
      setp(8'h5B);
      chk({7'h0, alert_oe}, 8'h01);
      setp(8'h5A);
      chk({7'h0, alert_oe}, 8'h00);
      setp(8'h5B);
      rd_ptr(8'h00, 8'h3B);
      wc(40);
      chk({7'h0, alert_oe}, 8'h00);
      // output pins moving must not raise the alert
      wr(8'h01, 8'h00);
      wc(40);
      chk({7'h0, alert_oe}, 8'h00);
      wr(8'h03, 8'hFF);
      wc(40);
      chk({7'h0, alert_oe}, 8'h01);
      rd_ptr(8'h00, 8'h5B);
      wc(40);
      chk({7'h0, alert_oe}, 8'h00);
   endtask : t_alert
   task automatic t_reads();
      logic [7:0] d;
      i_master.bus_start();
      put({4'h4, strap, 1'b0}, 1'b1);
      put(8'h01, 1'b1);
      i_master.bus_start();
      put({4'h4, strap, 1'b1}, 1'b1);
      i_master.get_byte(1'b0, d);
      chk(d, 8'h00);
      i_master.get_byte(1'b1, d);
      chk(d, 8'h00);
      i_master.get_byte(1'b1, d);
      chk(d, 8'hFF);
      i_master.bus_stop();
   endtask : t_reads
   task automatic t_mismatch();
      logic [7:0] d;
      put({4'h4, strap, 1'b0}, 1'b0);
      i_master.bus_start();
      put({4'h4, ~strap, 1'b1}, 1'b0);
      i_master.get_byte(1'b1, d);
      chk(d, 8'hFF);
      i_master.bus_stop();
      rd_again(8'h00);
   endtask : t_mismatch
   initial begin
      wc(6);
      rstn <= 1'b1;
      wc(10);
      t_reset();
      t_output();
      t_polarity();
      t_alert();
      t_reads();
      t_mismatch();
      summarize();
   end
   // the sequence needs some 20000 cycles
   initial begin
      wc(80000);
      errors++;
      summarize();
   end
endmodule : gpx_top_tb_top
